/* File: design/clock_timer.sv */
// clock timer: 8-bit counter, read hold, periodic interrupts
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module clock_timer #(
  parameter int TICK_DIVIDE =
    clock_timer_pkg::CLOCK_HZ / clock_timer_pkg::TICK_HZ,
  parameter int HOLD_CYCLES = clock_timer_pkg::HOLD_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [15:0] addr,
  input wire logic [3:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [3:0] rdata,
  // interrupt
  output logic irq
);
  clock_timer_pkg::bus_req_t req;
  logic tick;
  logic holding;
  logic count_run_control_r;
  logic [3:0] count_low_nibble_r;
  logic [3:0] count_high_nibble_r;
  logic high_pending_r;
  logic [3:0] enable_r;
  logic [3:0] flag_r;
  logic [3:0] fall;
  logic [7:0] count_value_bits;
  logic [7:0] count_nxt;
  logic clear_hit;
  logic low_read;
  logic high_read;
  logic [3:0] rdata_nxt;

  initial begin
    if (HOLD_CYCLES < 1 || TICK_DIVIDE < 2)
      $error("clock_timer: bad timing parameters");
  end

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign count_value_bits = {count_high_nibble_r, count_low_nibble_r};
  assign clear_hit = req.wr && hit(req.addr, clock_timer_pkg::OFS_CONTROL) &&
    req.wdata[clock_timer_pkg::BIT_CLEAR];
  assign low_read = req.rd && hit(req.addr, clock_timer_pkg::OFS_COUNT_LOW);
  assign high_read = req.rd && hit(req.addr, clock_timer_pkg::OFS_COUNT_HIGH);

  tick_divider #(.DIVIDE(TICK_DIVIDE)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  hold_timer #(.CYCLES(HOLD_CYCLES)) u_hold (
    .clock(clock),
    .rst_n(rst_n),
    .start(low_read),
    .stop(high_read),
    .holding(holding)
  );

  // run control
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_run_control_r <= 1'b0;
    end else if (req.wr && hit(req.addr, clock_timer_pkg::OFS_CONTROL)) begin
      count_run_control_r <= req.wdata[clock_timer_pkg::BIT_RUN];
    end
  end

  // low nibble counts on tick; carry into high is deferred while held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_low_nibble_r <= clock_timer_pkg::NIBBLE_RESET;
    end else if (clear_hit) begin
      count_low_nibble_r <= clock_timer_pkg::NIBBLE_RESET;
    end else if (count_run_control_r && tick) begin
      count_low_nibble_r <= count_low_nibble_r + 4'h1;
    end
  end

  // pending carry, set wins over release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_pending_r <= 1'b0;
    end else if (clear_hit) begin
      high_pending_r <= 1'b0;
    end else if (count_run_control_r && tick && count_low_nibble_r == 4'hF
                 && (holding || high_pending_r)) begin
      high_pending_r <= 1'b1;
    end else if (!holding) begin
      high_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_high_nibble_r <= clock_timer_pkg::NIBBLE_RESET;
    end else if (clear_hit) begin
      count_high_nibble_r <= clock_timer_pkg::NIBBLE_RESET;
    end else if (!holding && high_pending_r) begin
      count_high_nibble_r <= count_high_nibble_r + 4'h1;
    end else if (!holding && count_run_control_r && tick &&
                 count_low_nibble_r == 4'hF) begin
      count_high_nibble_r <= count_high_nibble_r + 4'h1;
    end
  end

  // falling edges of the event bits, from present and next count
  always_comb begin
    count_nxt = {count_high_nibble_r, count_low_nibble_r};
    if (clear_hit) begin
      count_nxt = clock_timer_pkg::COUNT_RESET;
    end else begin
      if (count_run_control_r && tick)
        count_nxt[3:0] = count_low_nibble_r + 4'h1;
      if (!holding && (high_pending_r || (count_run_control_r && tick &&
          count_low_nibble_r == 4'hF)))
        count_nxt[7:4] = count_high_nibble_r + 4'h1;
    end
    fall[0] = count_value_bits[clock_timer_pkg::EV_BIT_32HZ] &&
      !count_nxt[clock_timer_pkg::EV_BIT_32HZ];
    fall[1] = count_value_bits[clock_timer_pkg::EV_BIT_8HZ] &&
      !count_nxt[clock_timer_pkg::EV_BIT_8HZ];
    fall[2] = count_value_bits[clock_timer_pkg::EV_BIT_2HZ] &&
      !count_nxt[clock_timer_pkg::EV_BIT_2HZ];
    fall[3] = count_value_bits[clock_timer_pkg::EV_BIT_1HZ] &&
      !count_nxt[clock_timer_pkg::EV_BIT_1HZ];
  end

  // enable bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= 4'h0;
    end else if (req.wr && hit(req.addr, clock_timer_pkg::OFS_IRQ_ENABLE)) begin
      enable_r <= req.wdata;
    end
  end

  // flags: event set wins over write-one clear
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_flag
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          flag_r[i] <= 1'b0;
        end else if (fall[i]) begin
          flag_r[i] <= 1'b1;
        end else if (req.wr && hit(req.addr, clock_timer_pkg::OFS_IRQ_FLAGS)
                     && req.wdata[i]) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_r & enable_r);
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = 4'h0;
    if (req.rd) begin
      case (req.addr)
        clock_timer_pkg::OFS_CONTROL:
          rdata_nxt = {3'h0, count_run_control_r};
        clock_timer_pkg::OFS_COUNT_LOW: rdata_nxt = count_low_nibble_r;
        clock_timer_pkg::OFS_COUNT_HIGH:
          rdata_nxt = count_high_nibble_r;
        clock_timer_pkg::OFS_IRQ_ENABLE: rdata_nxt = enable_r;
        clock_timer_pkg::OFS_IRQ_FLAGS: rdata_nxt = flag_r;
        default: rdata_nxt = 4'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 4'h0;
    end else begin
      rdata <= rdata_nxt;
    end
  end
endmodule

/* File: design/clock_timer_pkg.sv */
// constants and types for the clock timer with read hold
// Operation
// - the timer is an eight-bit binary counter fed by a prescaled crystal clock.
// - count bits 0-3 read in the low word and bits 4-7 in the high word.
// - a low-word read stops carries into the high nibble until a high read or a hold timeout.
// - a flag is set on each falling edge of the 32, 8, 2 and 1 Hz count bits.
// - flags are set whatever the enable bits hold.
// - four enable bits, readable and writable, clear at reset.
// - four flags read as set on an event, and a written one clears a flag.
// - all flags clear at reset.
// - the request stays active while an enabled flag stays set.
// - writing one to the clear bit zeroes the counter, and the bit reads zero.
// - the run bit is readable, one runs, zero stops, and it resets to zero.
// - in stop the count is held and resumes from that value on run.
// - count bits are read-only and reset to zero.
package clock_timer_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_CONTROL = 16'hFF78;
  localparam logic [15:0] OFS_COUNT_LOW = 16'hFF79;
  localparam logic [15:0] OFS_COUNT_HIGH = 16'hFF7A;
  localparam logic [15:0] OFS_IRQ_ENABLE = 16'hFFE6;
  localparam logic [15:0] OFS_IRQ_FLAGS = 16'hFFF6;
  localparam int BIT_RUN = 0;
  localparam int BIT_CLEAR = 1;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // count bit index for each event: 32, 8, 2, 1 Hz
  localparam int EV_BIT_32HZ = 2;
  localparam int EV_BIT_8HZ = 4;
  localparam int EV_BIT_2HZ = 6;
  localparam int EV_BIT_1HZ = 7;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int TICK_HZ = 256;
  // hold time, shortest documented figure, in microseconds
  localparam int HOLD_US = 480;
  localparam int HOLD_CYCLES = HOLD_US * (CLOCK_HZ / 1_000_000);

  typedef struct packed {
    logic [15:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

/* File: design/tick_divider.sv */
// divides the system clock down to a one-cycle tick pulse
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIVIDE = 39063
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // tick out
  output logic tick
);
  localparam int CW = $clog2(DIVIDE + 1);
  logic [CW-1:0] cnt_r;

  initial begin
    if (DIVIDE < 2) $error("tick_divider: DIVIDE must be at least 2");
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (cnt_r == CW'(DIVIDE - 1)) begin
      cnt_r <= '0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

/* File: design/hold_timer.sv */
// times the high-nibble hold window after a low-word read
`timescale 1ns/1ps
module hold_timer #(
  parameter int CYCLES = 4800
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic stop,
  // state
  output logic holding
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;

  initial begin
    if (CYCLES < 1) $error("hold_timer: CYCLES must be at least 1");
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      holding <= 1'b0;
    end else if (start) begin
      cnt_r <= CW'(CYCLES - 1);
      holding <= 1'b1;
    end else if (stop || cnt_r == '0) begin
      cnt_r <= '0;
      holding <= 1'b0;
    end else begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

/* File: testbench/clock_timer_sva.sv */
// checker for the clock timer register port and interrupt output
`timescale 1ns/1ps
module clock_timer_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [15:0] addr,
  input wire logic [3:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] rdata,
  // interrupt
  input wire logic irq
);
  logic [3:0] en_r;
  logic run_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // mirrors of the enable and run bits as written by software
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 4'h0;
      run_r <= 1'b0;
    end else if (wr && addr == 16'hFFE6) begin
      en_r <= wdata;
    end else if (wr && addr == 16'hFF78) begin
      run_r <= wdata[0];
    end
  end
  a_run_readback: assert property (rd && addr == 16'hFF78 |=>
    rdata[0] == $past(run_r)) else $error("run bit readback wrong");
  a_clear_reads_zero: assert property (rd && addr == 16'hFF78 |=>
    rdata[3:1] == 3'h0) else $error("control upper bits not zero");
  a_enable_readback: assert property (rd && addr == 16'hFFE6 |=>
    rdata == $past(en_r)) else $error("enable readback wrong");
  a_stopped_low_stable: assert property (
    rd && addr == 16'hFF79 && !run_r ##1 rd && addr == 16'hFF79 |=>
    $stable(rdata)) else $error("count moved while stopped");
  a_count_read_only: assert property (
    rd && addr == 16'hFF79 && !run_r ##1 wr && addr == 16'hFF79 ##1
    rd && addr == 16'hFF79 |=> rdata == $past(rdata, 2))
    else $error("count changed by a write");
  a_flags_drive_irq: assert property (rd && addr == 16'hFFF6 |=>
    irq == |(rdata & $past(en_r))) else $error("irq not flags and enables");
  a_masked_irq_low: assert property ($past(en_r) == 4'h0 |->
    !irq) else $error("irq high with all events masked");
  a_flag_clear_irq: assert property (
    wr && addr == 16'hFFF6 && wdata == 4'hF && !run_r |-> ##2 !irq)
    else $error("irq stayed high after clearing all flags");
  c_irq_rise: cover property ($rose(irq));
  c_write_count: cover property (wr && addr == 16'hFF79);
  c_flag_clear: cover property (wr && addr == 16'hFFF6 && wdata == 4'hF);
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the clock timer
`timescale 1ns/1ps
module testbench;
  logic clock, rst_n, wr, rd, irq;
  logic [15:0] addr;
  logic [3:0] wdata, rdata, v, c;
  int err_total, comparisons;
  clock_timer #(.TICK_DIVIDE(4), .HOLD_CYCLES(10)) DUT (.clock(clock),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // one bus cycle; read data are captured after the taking edge
  task automatic cyc(input logic w, input logic r, input logic [15:0] a,
    input logic [3:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    #1 v = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 16'h0000, 4'h0);
  endtask
  task automatic chk4(input string s, input logic [3:0] e,
    input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [3:0] e);
    cyc(1'b0, 1'b1, a, 4'h0);
    chk4($sformatf("read %h", a), e, v);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 4'h0;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    rchk(16'hFF78, 4'h0);
    rchk(16'hFF79, 4'h0);
    rchk(16'hFF7A, 4'h0);
    rchk(16'hFFE6, 4'h0);
    rchk(16'hFFF6, 4'h0);
    cyc(1'b1, 1'b0, 16'hFFE6, 4'hA);
    rchk(16'hFFE6, 4'hA);
    cyc(1'b1, 1'b0, 16'hFFE6, 4'h0);
    $display("test reset done");
    cyc(1'b1, 1'b0, 16'hFF78, 4'h3);
    rchk(16'hFF78, 4'h1);
    idle(1100);
    cyc(1'b1, 1'b0, 16'hFF78, 4'h0);
    rchk(16'hFF78, 4'h0);
    cyc(1'b0, 1'b1, 16'hFF79, 4'h0);
    cyc(1'b0, 1'b1, 16'hFF79, 4'h0);
    c = v;
    cyc(1'b1, 1'b0, 16'hFF79, 4'h5);
    rchk(16'hFF79, c);
    chk4("low range", 4'h1, {3'h0, c inside {[2:5]}});
    rchk(16'hFF7A, 4'h1);
    rchk(16'hFFF6, 4'hF);
    chk4("irq masked", 4'h0, {3'h0, irq});
    $display("test count done");
    cyc(1'b1, 1'b0, 16'hFFE6, 4'hF);
    idle(1);
    chk4("irq on", 4'h1, {3'h0, irq});
    cyc(1'b1, 1'b0, 16'hFFF6, 4'h1);
    rchk(16'hFFF6, 4'hE);
    cyc(1'b1, 1'b0, 16'hFFE6, 4'h1);
    idle(1);
    chk4("irq cleared", 4'h0, {3'h0, irq});
    cyc(1'b1, 1'b0, 16'hFFE6, 4'hE);
    idle(1);
    chk4("irq again", 4'h1, {3'h0, irq});
    cyc(1'b1, 1'b0, 16'hFFF6, 4'hF);
    idle(1);
    chk4("irq off", 4'h0, {3'h0, irq});
    rchk(16'hFFF6, 4'h0);
    $display("test irq done");
    cyc(1'b1, 1'b0, 16'hFF78, 4'h3);
    for (int i = 0; i < 100 && v !== 4'hF; i++) begin
      cyc(1'b0, 1'b1, 16'hFF79, 4'h0);
    end
    if (v !== 4'hF) begin
      err_total++;
      $display("Error low nibble wait expected f seen %h", v);
    end else begin
      idle(6);
      rchk(16'hFF7A, 4'h0);
      idle(20);
      rchk(16'hFF7A, 4'h1);
      $display("test hold done");
      // clear written together with stop keeps the zeroed count
      cyc(1'b1, 1'b0, 16'hFF78, 4'h2);
      idle(8);
      rchk(16'hFF79, 4'h0);
      rchk(16'hFF7A, 4'h0);
      rchk(16'hFF78, 4'h0);
      $display("test clear done");
    end
    end_of_test;
  end
endmodule
bind clock_timer clock_timer_sva u_sva (.clock(clock), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
